// *** mld_decode.sv ***
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "mld_consts.svh"

module mld_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output mld_pkg::mld_phase_type phase
);
    import mld_pkg::*;

    mld_phase_type phase_ff;
    mld_op_type op_ff;
    mld_op_type pend_ff;
    mld_op_type nxt_op;
    logic [15:0] ir_ff;
    logic [11:0] addr_ff;
    logic [11:0] nxt_addr;
    logic [7:0] acc_ff;
    logic [7:0] bank_ff;
    logic [7:0] flags_ff;
    logic [7:0] data_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    logic [1:0] psel_ff;
    logic [11:0] ptr_ff [0:2];
    logic ext_en_ff;
    logic [7:0] src_val;
    logic [7:0] result;
    logic dest_file;
    logic hits_acc;
    logic wr_mem;
    logic wr_acc;

    // effective data address of a single-word file operand
    function automatic logic [11:0] file_addr(
        input logic a,
        input logic [7:0] f,
        input logic [7:0] bank,
        input logic ext,
        input logic [11:0] idx
    );
        logic [11:0] r;
        r = {bank[3:0], f};
        if (!a && ext && (f <= `MLD_IDX_MAX)) begin
            r = idx + {`MLD_ACC_LO, f};
        end else if (!a) begin
            r = (f >= `MLD_ACC_SPLIT) ? {`MLD_ACC_HI, f} : {`MLD_ACC_LO, f};
        end
        return r;
    endfunction

    function automatic logic reads_file(input mld_op_type op);
        return (op == MLD_OR_ACC_INTO_FILE) || (op == MLD_MOVE_FILE_OP)
            || (op == MLD_F2F_FIRST);
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_ff <= MLD_Q1;
        end else begin
            unique case (phase_ff)
                MLD_Q1: phase_ff <= MLD_Q2;
                MLD_Q2: phase_ff <= MLD_Q3;
                MLD_Q3: phase_ff <= MLD_Q4;
                MLD_Q4: phase_ff <= MLD_Q1;
            endcase
        end
    end

    assign phase = phase_ff;
    assign instr_ready = (phase_ff == MLD_Q1);

    // a pending first word claims the next taken word as its partner
    always_comb begin
        nxt_op = MLD_NONE;
        if (pend_ff == MLD_PTR_FIRST) begin
            if (instr_word[15:8] == `MLD_PTR_W2) begin
                nxt_op = MLD_PTR_SECOND;
            end
        end else if (pend_ff == MLD_F2F_FIRST) begin
            if (instr_word[15:12] == `MLD_NIB_FF2) begin
                nxt_op = MLD_F2F_SECOND;
            end
        end else if (instr_word[15:12] == `MLD_NIB_IOR && instr_word[11:10] == `MLD_SUB_DA) begin
            nxt_op = MLD_OR_ACC_INTO_FILE;
        end else if (instr_word[15:12] == `MLD_NIB_MOVE_FILE_OP && instr_word[11:10] == `MLD_SUB_DA) begin
            nxt_op = MLD_MOVE_FILE_OP;
        end else if (instr_word[15:12] == `MLD_NIB_STORE && instr_word[11:9] == `MLD_SUB_STORE) begin
            nxt_op = MLD_STORE_ACC_TO_FILE;
        end else if (instr_word[15:8] == `MLD_BYTE_BANK) begin
            nxt_op = MLD_LOAD_BANK_LITERAL;
        end else if (instr_word[15:8] == `MLD_BYTE_LIT) begin
            nxt_op = MLD_LOAD_ACC_LITERAL;
        end else if (instr_word[15:6] == `MLD_PTR_W1 && instr_word[5:4] <= `MLD_PTR_LAST) begin
            nxt_op = MLD_PTR_FIRST;
        end else if (instr_word[15:12] == `MLD_NIB_FF1) begin
            nxt_op = MLD_F2F_FIRST;
        end
    end

    always_comb begin
        nxt_addr = instr_word[11:0];
        if (nxt_op == MLD_OR_ACC_INTO_FILE || nxt_op == MLD_MOVE_FILE_OP
            || nxt_op == MLD_STORE_ACC_TO_FILE) begin
            nxt_addr = file_addr(instr_word[8], instr_word[7:0], bank_ff, ext_en_ff,
                ptr_ff[`MLD_PTR_IDX]);
        end
    end

    // instruction capture in the decode phase
    always_ff @(posedge clk) begin
        if (rst) begin
            op_ff <= MLD_NONE;
            ir_ff <= 16'h0000;
            addr_ff <= `MLD_ZERO12;
        end else if (phase_ff == MLD_Q1) begin
            op_ff <= instr_valid ? nxt_op : MLD_NONE;
            ir_ff <= instr_word;
            addr_ff <= nxt_addr;
        end
    end

    // a pending first word is held across cycles with no valid word until the next taken word
    // wait for second word
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_ff <= MLD_NONE;
        end else if (phase_ff == MLD_Q1 && instr_valid) begin
            if (nxt_op == MLD_PTR_FIRST || nxt_op == MLD_F2F_FIRST) begin
                pend_ff <= nxt_op;
            end else begin
                pend_ff <= MLD_NONE;
            end
        end
    end

    assign hits_acc = (addr_ff == `MLD_ACC_ADDR);
    assign src_val = hits_acc ? acc_ff : mem_rdata;
    assign dest_file = ir_ff[9];

    always_comb begin
        unique case (op_ff)
            MLD_OR_ACC_INTO_FILE: result = acc_ff | src_val;
            MLD_MOVE_FILE_OP: result = src_val;
            MLD_STORE_ACC_TO_FILE: result = acc_ff;
            MLD_F2F_SECOND: result = data_ff;
            default: result = `MLD_ZERO8;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_ff <= `MLD_ZERO8;
            wdata_ff <= `MLD_ZERO8;
        end else if (phase_ff == MLD_Q3) begin
            if (op_ff == MLD_F2F_FIRST) begin
                data_ff <= src_val;
            end
            wdata_ff <= result;
        end
    end

    assign mem_addr = addr_ff;
    assign mem_wdata = wdata_ff;
    // no bus read for the mapped accumulator; the byte comes from acc_ff
    assign mem_rd = (phase_ff == MLD_Q2) && reads_file(op_ff) && !hits_acc;

    always_comb begin
        wr_mem = 1'b0;
        wr_acc = 1'b0;
        unique case (op_ff)
            MLD_OR_ACC_INTO_FILE, MLD_MOVE_FILE_OP: begin
                wr_mem = dest_file && !hits_acc;
                wr_acc = !dest_file || hits_acc;
            end
            MLD_STORE_ACC_TO_FILE, MLD_F2F_SECOND: begin
                wr_mem = !hits_acc;
                wr_acc = hits_acc;
            end
            MLD_LOAD_ACC_LITERAL: wr_acc = 1'b1;
            default: wr_acc = 1'b0;
        endcase
    end

    assign mem_wr = (phase_ff == MLD_Q4) && wr_mem;

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_ff <= `MLD_ZERO8;
        end else if (phase_ff == MLD_Q4 && wr_acc) begin
            if (op_ff == MLD_LOAD_ACC_LITERAL) begin
                acc_ff <= ir_ff[7:0];
            end else begin
                acc_ff <= wdata_ff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_ff <= `MLD_ZERO8;
        end else if (phase_ff == MLD_Q4 && (op_ff == MLD_OR_ACC_INTO_FILE
            || op_ff == MLD_MOVE_FILE_OP)) begin
            flags_ff[`MLD_FLAG_N] <= wdata_ff[7];
            flags_ff[`MLD_FLAG_Z] <= (wdata_ff == `MLD_ZERO8);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bank_ff <= `MLD_ZERO8;
        end else if (phase_ff == MLD_Q4 && op_ff == MLD_LOAD_BANK_LITERAL) begin
            bank_ff <= ir_ff[7:0] & `MLD_BANK_MASK;
        end
    end

    // selector held until the low byte arrives with the second word
    always_ff @(posedge clk) begin
        if (rst) begin
            psel_ff <= 2'h0;
        end else if (phase_ff == MLD_Q4 && op_ff == MLD_PTR_FIRST) begin
            psel_ff <= ir_ff[5:4];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                ptr_ff[i] <= `MLD_ZERO12;
            end
        end else if (phase_ff == MLD_Q4 && op_ff == MLD_PTR_FIRST) begin
            ptr_ff[ir_ff[5:4]][11:8] <= ir_ff[3:0];
        end else if (phase_ff == MLD_Q4 && op_ff == MLD_PTR_SECOND) begin
            ptr_ff[psel_ff][7:0] <= ir_ff[7:0];
        end
    end

    // software control; only the extended-set switch is writable
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_en_ff <= 1'b0;
        end else if (reg_wr && reg_addr == `MLD_REG_CTRL) begin
            ext_en_ff <= reg_wdata[`MLD_CTRL_EXT];
        end
    end

    // read data lands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= `MLD_ZERO8;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `MLD_REG_CTRL: rdata_ff <= {7'h00, ext_en_ff};
                `MLD_REG_ACC: rdata_ff <= acc_ff;
                `MLD_REG_BANK: rdata_ff <= bank_ff;
                `MLD_REG_FLAGS: rdata_ff <= flags_ff;
                `MLD_REG_P0L: rdata_ff <= ptr_ff[0][7:0];
                `MLD_REG_P0H: rdata_ff <= {4'h0, ptr_ff[0][11:8]};
                `MLD_REG_P1L: rdata_ff <= ptr_ff[1][7:0];
                `MLD_REG_P1H: rdata_ff <= {4'h0, ptr_ff[1][11:8]};
                `MLD_REG_P2L: rdata_ff <= ptr_ff[2][7:0];
                `MLD_REG_P2H: rdata_ff <= {4'h0, ptr_ff[2][11:8]};
                default: rdata_ff <= `MLD_ZERO8;
            endcase
        end else begin
            rdata_ff <= `MLD_ZERO8;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule // mld_decode

// *** mld_consts.svh ***
// Notes on behaviour
// - opcode 0001 00da ffff ffff ORs accumulator with the addressed file byte.
// - the OR updates only negative and zero flags; other flags are kept.
// - destination bit 0 writes the accumulator, 1 writes back the file byte.
// - bank bit 0 uses the quick access bank, 1 uses bank select plus field.
// - bank bit 0, extended set on, field up to 5Fh: indexed literal offset.
// - opcode 0101 00da copies the file byte to destination, sets N and Z.
// - the 8-bit file field reaches any byte of the selected 256-byte bank.
// - pointer load puts a 12-bit literal in the named pointer, flags untouched.
// - file-to-file move uses full 12-bit addresses and changes no flags.
// - file-to-file move is two words, leading nibbles 1100 then 1111.
// - the accumulator may be source or destination through its mapped address.
// - file-to-file move takes 2 cycles; read first, write end of second.
// - bank literal load writes bank select, bits 7:4 always stay zero.
// - accumulator literal load writes the literal in the last phase, one cycle.
// - opcode 0110 111a stores the accumulator into the file byte, no flags.
`ifndef MLD_CONSTS_SVH
`define MLD_CONSTS_SVH

`define MLD_NIB_IOR 4'h1
`define MLD_NIB_MOVE_FILE_OP 4'h5
`define MLD_SUB_DA 2'h0
`define MLD_NIB_STORE 4'h6
`define MLD_SUB_STORE 3'h7
`define MLD_BYTE_BANK 8'h01
`define MLD_BYTE_LIT 8'h0e
`define MLD_PTR_W1 10'h3b8
`define MLD_PTR_W2 8'hf0
`define MLD_NIB_FF1 4'hc
`define MLD_NIB_FF2 4'hf

`define MLD_ACC_ADDR 12'hfe8
`define MLD_IDX_MAX 8'h5f
`define MLD_ACC_SPLIT 8'h60
`define MLD_ACC_HI 4'hf
`define MLD_ACC_LO 4'h0
`define MLD_BANK_MASK 8'h0f
`define MLD_PTR_IDX 2'h2
`define MLD_PTR_LAST 2'h2

`define MLD_FLAG_Z 2
`define MLD_FLAG_N 4
`define MLD_ZERO8 8'h00
`define MLD_ZERO12 12'h000

`define MLD_REG_CTRL 4'h0
`define MLD_REG_ACC 4'h1
`define MLD_REG_BANK 4'h2
`define MLD_REG_FLAGS 4'h3
`define MLD_REG_P0L 4'h4
`define MLD_REG_P0H 4'h5
`define MLD_REG_P1L 4'h6
`define MLD_REG_P1H 4'h7
`define MLD_REG_P2L 4'h8
`define MLD_REG_P2H 4'h9
`define MLD_CTRL_EXT 0

`endif

// *** mld_pkg.sv ***
package mld_pkg;

    typedef enum logic [3:0] {
        MLD_Q1 = 4'b0001,
        MLD_Q2 = 4'b0010,
        MLD_Q3 = 4'b0100,
        MLD_Q4 = 4'b1000
    } mld_phase_type;

    typedef enum logic [9:0] {
        MLD_NONE = 10'b00_0000_0001,
        MLD_OR_ACC_INTO_FILE = 10'b00_0000_0010,
        MLD_MOVE_FILE_OP = 10'b00_0000_0100,
        MLD_STORE_ACC_TO_FILE = 10'b00_0000_1000,
        MLD_LOAD_BANK_LITERAL = 10'b00_0001_0000,
        MLD_LOAD_ACC_LITERAL = 10'b00_0010_0000,
        MLD_PTR_FIRST = 10'b00_0100_0000,
        MLD_PTR_SECOND = 10'b00_1000_0000,
        MLD_F2F_FIRST = 10'b01_0000_0000,
        MLD_F2F_SECOND = 10'b10_0000_0000
    } mld_op_type;

endpackage

// *** mld_decode_sva.sv ***
`timescale 1ns/10ps
module mld_decode_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire mld_pkg::mld_phase_type phase
);
    import mld_pkg::*;
    logic take;
    logic [3:0] prev_ph_ff;
    assign take = instr_ready && instr_valid;
    always_ff @(posedge clk) begin
        prev_ph_ff <= phase;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    phase_step_a: assert property (!$past(rst) |-> phase == {prev_ph_ff[2:0], prev_ph_ff[3]})
        else $error("phase did not advance one step");
    ready_slot_a: assert property (instr_ready == (phase == MLD_Q1))
        else $error("ready outside the decode phase");
    read_phase_a: assert property (mem_rd |-> phase == MLD_Q2)
        else $error("read strobe outside second phase");
    write_phase_a: assert property (mem_wr |-> phase == MLD_Q4)
        else $error("write strobe outside last phase");
    addr_hold_a: assert property (phase != MLD_Q2 && !$past(rst) |-> $stable(mem_addr))
        else $error("address moved mid cycle");
    or_dest_a: assert property (take && instr_word[15:10] == 6'h04 |->
        ##1 (mem_rd || mem_addr == 12'hfe8)
        ##2 (mem_wr == $past(instr_word[9], 3) || mem_addr == 12'hfe8))
        else $error("or result sent to wrong place");
    store_write_a: assert property (take && instr_word[15:9] == 7'h37 |->
        ##1 !mem_rd ##2 (mem_wr || mem_addr == 12'hfe8))
        else $error("store did not write file");
    lit_quiet_a: assert property (take && (instr_word[15:8] == 8'h0e || instr_word[15:8] == 8'h01)
        |-> ##1 (!mem_rd && !mem_wr) [*3])
        else $error("literal load touched memory");
    f2f_src_a: assert property (take && instr_word[15:12] == 4'hc && instr_word[11:0] != 12'hfe8
        |-> ##1 mem_rd && mem_addr == $past(instr_word[11:0]))
        else $error("move source not read first");
endmodule // mld_decode_sva

bind mld_decode mld_decode_sva chk_u (.clk(clk), .rst(rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .phase(phase));

// *** mld_mem_model.sv ***
`timescale 1ns/10ps
module mld_mem_model (
    input wire logic clk,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_ff [0:4095];
    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 4096; i++) begin
            mem_ff[i] = 8'h00;
        end
    end
    // data lines toggle outside the answer cycle so a stale byte never looks fresh
    always @(posedge clk) begin
        if (mem_wr) begin
            mem_ff[mem_addr] <= mem_wdata;
        end
        mem_rdata <= mem_rd ? mem_ff[mem_addr] : ~mem_rdata;
    end
endmodule // mld_mem_model

// *** move_or_load_instr_decode_bench.sv ***
`timescale 1ns/10ps
module move_or_load_instr_decode_bench;
    import mld_pkg::*;
    logic clk, rst, instr_valid, instr_ready, mem_rd, mem_wr, reg_wr, reg_rd;
    logic [15:0] instr_word;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, reg_wdata, reg_rdata, rv;
    logic [3:0] reg_addr;
    mld_phase_type phase;
    int err_total, comparisons;

    mld_decode dut_u (.clk(clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .phase(phase));
    mld_mem_model mem_u (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rv = reg_rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // f low returns at once so a second word can follow in the very next slot
    task automatic run(input logic [15:0] w, input bit f = 1'b1);
        int n;
        n = 0;
        @(negedge clk);
        while (phase !== MLD_Q4) begin
            n++;
            if (n > 8) begin
                err_total++;
                $display("mismatch at %0t: no decode slot", $time);
                wrap_up();
            end
            @(negedge clk);
        end
        @(posedge clk);
        instr_word <= w;
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        if (f) begin
            repeat (3) @(posedge clk);
            @(negedge clk);
        end
    endtask

    task automatic t_lit;
        run(16'h0e5a);
        rd(4'h1);
        chk(rv, 8'h5a);
        wr(4'h1, 8'h11);
        rd(4'h1);
        chk(rv, 8'h5a);
        run(16'h01f7);
        rd(4'h2);
        chk(rv, 8'h07);
    endtask

    task automatic t_or;
        mem_u.mem_ff[12'h025] = 8'h13;
        run(16'h0e91);
        run(16'h1025);
        rd(4'h1);
        chk(rv, 8'h93);
        rd(4'h3);
        chk(rv, 8'h10);
        run(16'h0102);
        mem_u.mem_ff[12'h2a0] = 8'h0c;
        run(16'h13a0);
        chk(mem_u.mem_ff[12'h2a0], 8'h9f);
        run(16'h1270);
        chk(mem_u.mem_ff[12'hf70], 8'h93);
    endtask

    task automatic t_move_file_op;
        run(16'h5030);
        rd(4'h1);
        chk(rv, 8'h00);
        rd(4'h3);
        chk(rv, 8'h04);
        run(16'h53a0);
        rd(4'h3);
        chk(rv, 8'h10);
        chk(mem_u.mem_ff[12'h2a0], 8'h9f);
    endtask

    task automatic t_store;
        run(16'h0ec3);
        run(16'h6f55);
        chk(mem_u.mem_ff[12'h255], 8'hc3);
        rd(4'h3);
        chk(rv, 8'h10);
    endtask

    task automatic t_ptr;
        wr(4'h0, 8'h01);
        run(16'hee23);
        rd(4'h9);
        chk(rv, 8'h03);
        rd(4'h8);
        chk(rv, 8'h00);
        run(16'hf0ab);
        rd(4'h8);
        chk(rv, 8'hab);
        rd(4'h3);
        chk(rv, 8'h10);
        run(16'h6e5f);
        chk(mem_u.mem_ff[12'h40a], 8'hc3);
        run(16'h6e60);
        chk(mem_u.mem_ff[12'hf60], 8'hc3);
        run(16'hee3f);
        run(16'hf044);
        rd(4'h8);
        chk(rv, 8'hab);
        rd(4'h9);
        chk(rv, 8'h03);
        run(16'hee05);
        run(16'h0e77);
        rd(4'h1);
        chk(rv, 8'hc3);
        rd(4'h5);
        chk(rv, 8'h05);
        rd(4'h4);
        chk(rv, 8'h00);
        wr(4'h0, 8'h00);
    endtask

    task automatic t_f2f;
        mem_u.mem_ff[12'h000] = 8'h5a;
        // destinations kept off the counter and stack bytes
        run(16'hc000, 1'b0);
        run(16'hffff);
        chk(mem_u.mem_ff[12'hfff], 8'h5a);
        run(16'hc000, 1'b0);
        run(16'hffe8);
        rd(4'h1);
        chk(rv, 8'h5a);
        run(16'hcfe8);
        run(16'hf7ff);
        chk(mem_u.mem_ff[12'h7ff], 8'h5a);
        rd(4'h3);
        chk(rv, 8'h10);
    endtask

    // mid-run reset clears state and a pending first word
    task automatic t_reset;
        run(16'hee13);
        rd(4'h7);
        chk(rv, 8'h03);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(phase, MLD_Q1);
        chk(instr_ready, 1'b1);
        rd(4'h1);
        chk(rv, 8'h00);
        rd(4'h2);
        chk(rv, 8'h00);
        rd(4'h3);
        chk(rv, 8'h00);
        rd(4'h9);
        chk(rv, 8'h00);
        run(16'hf0cd);
        rd(4'h6);
        chk(rv, 8'h00);
        rd(4'h7);
        chk(rv, 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_lit();
        t_or();
        t_move_file_op();
        t_store();
        t_ptr();
        t_f2f();
        t_reset();
        wrap_up();
    end
endmodule // move_or_load_instr_decode_bench
